// [src/psepm_pkg.sv]
/*
 * Constants and types shared by the port mode controller ends.
 * Assumes one 25 MHz core clock and an active-low asynchronous reset.
 */
package psepm_pkg;

    localparam int PSEPM_PORTS = 8;

    // Mode field codes
    localparam logic [1:0] PSEPM_MODE_SHUT = 2'h0;
    localparam logic [1:0] PSEPM_MODE_MAN = 2'h1;
    localparam logic [1:0] PSEPM_MODE_SEMI = 2'h2;
    localparam logic [1:0] PSEPM_MODE_AUTO = 2'h3;

    // Detect result codes
    localparam logic [2:0] PSEPM_DET_UNKNOWN = 3'h0;
    localparam logic [2:0] PSEPM_DET_GOOD = 3'h4;

    // Class codes
    localparam logic [2:0] PSEPM_CLASS_0 = 3'h0;
    localparam logic [2:0] PSEPM_CLASS_4 = 3'h4;

    // Power in tenths of a watt
    localparam logic [9:0] PSEPM_PWR_387 = 10'h183;
    localparam logic [9:0] PSEPM_PWR_527 = 10'h20f;
    localparam logic [9:0] PSEPM_PWR_700 = 10'h2bc;
    localparam logic [9:0] PSEPM_PWR_900 = 10'h384;
    localparam logic [9:0] PSEPM_PWR_BASE = 10'h082;

    // Thresholds in mA
    localparam logic [9:0] PSEPM_CUT_C1 = 10'h070;
    localparam logic [9:0] PSEPM_CUT_C2 = 10'h0ce;
    localparam logic [9:0] PSEPM_CUT_C3 = 10'h177;
    localparam logic [9:0] PSEPM_CUT_C4 = 10'h27e;
    localparam logic [9:0] PSEPM_LIM_LO = 10'h1a9;
    localparam logic [9:0] PSEPM_LIM_HI = 10'h352;

    // Backoff times
    localparam int PSEPM_CLK_HZ = 25000000;
    localparam int PSEPM_WAIT_MS = 100;
    localparam int PSEPM_WAIT_MID_MS = 2000;
    localparam int PSEPM_WAIT_CYC = PSEPM_CLK_HZ / 1000 * PSEPM_WAIT_MS;
    localparam int PSEPM_WAIT_MID_CYC =
        PSEPM_CLK_HZ / 1000 * PSEPM_WAIT_MID_MS;

    // Host command codes
    localparam logic [2:0] PSEPM_CMD_NONE = 3'h0;
    localparam logic [2:0] PSEPM_CMD_DETECT = 3'h1;
    localparam logic [2:0] PSEPM_CMD_CLASS = 3'h2;
    localparam logic [2:0] PSEPM_CMD_PWR_ON = 3'h3;
    localparam logic [2:0] PSEPM_CMD_PWR_OFF = 3'h4;

    typedef enum logic [2:0] {
        PSEPM_ST_IDLE,
        PSEPM_ST_DETECT,
        PSEPM_ST_CLASS,
        PSEPM_ST_WAIT,
        PSEPM_ST_ON
    } psepm_state_t;

endpackage : psepm_pkg

// [src/psepm_if.sv]
/*
 * Carrier between host end and device end.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
interface psepm_if;
    import psepm_pkg::*;
    logic cmd_valid;
    logic [2:0] cmd_port;
    logic [2:0] cmd_code;
    logic [15:0] mode_field;
    logic [7:0] det_en;
    logic [7:0] class_en;
    logic [7:0] disc_en;
    logic high_power_en;
    logic ext_power_en;
    logic [7:0] port_power;
    logic [7:0] startup_fault;
    logic [23:0] det_status;
    logic [23:0] class_status;
    logic auto_sampled;

    modport host (output cmd_valid, cmd_port, cmd_code, mode_field,
        det_en, class_en, disc_en, high_power_en, ext_power_en,
        input port_power, startup_fault, det_status, class_status,
        auto_sampled);
    modport dev (input cmd_valid, cmd_port, cmd_code, mode_field,
        det_en, class_en, disc_en, high_power_en, ext_power_en,
        output port_power, startup_fault, det_status, class_status,
        auto_sampled);
endinterface : psepm_if
`default_nettype wire

// [src/psepm_host.sv]
/*
 * Host end: holds the settings it drives and forwards user commands.
 * Assumes user requests are synchronous to ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module psepm_host
    import psepm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    psepm_if.host link,
    input wire logic user_cmd_valid,
    input wire logic [2:0] user_cmd_port,
    input wire logic [2:0] user_cmd_code,
    input wire logic cfg_we,
    input wire logic [2:0] cfg_port,
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_det_en,
    input wire logic cfg_class_en,
    input wire logic cfg_disc_en,
    input wire logic cfg_high_power_en,
    input wire logic cfg_ext_power_en,
    output logic [7:0] user_power,
    output logic [7:0] user_fault
);
    typedef struct packed {
        logic [15:0] mode;
        logic [7:0] det;
        logic [7:0] cls;
        logic [7:0] disc;
        logic hp;
        logic ext;
        logic cv;
        logic [2:0] cp;
        logic [2:0] cc;
        logic [7:0] pwr;
        logic [7:0] flt;
    } psepm_host_t;

    psepm_host_t r;
    psepm_host_t next_r;

    ////////////////////////////////////////////////////////////////////
    // Settings and command registers
    always_comb
    begin
        next_r = r;
        next_r.cv = user_cmd_valid;
        next_r.cp = user_cmd_port;
        next_r.cc = user_cmd_code;
        next_r.pwr = link.port_power;
        next_r.flt = link.startup_fault;
        if (cfg_we)
        begin
            next_r.mode[cfg_port*2 +: 2] = cfg_mode;
            next_r.det[cfg_port] = cfg_det_en;
            next_r.cls[cfg_port] = cfg_class_en;
            next_r.disc[cfg_port] = cfg_disc_en;
            next_r.hp = cfg_high_power_en;
            next_r.ext = cfg_ext_power_en;
        end
    end

    // State register; every port clears to shutdown
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            r <= '0;
        else
            r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////
    // Link drive
    assign link.cmd_valid = r.cv;
    assign link.cmd_port = r.cp;
    assign link.cmd_code = r.cc;
    assign link.mode_field = r.mode;
    assign link.det_en = r.det;
    assign link.class_en = r.cls;
    assign link.disc_en = r.disc;
    assign link.high_power_en = r.hp;
    assign link.ext_power_en = r.ext;
    assign user_power = r.pwr;
    assign user_fault = r.flt;
endmodule : psepm_host
`default_nettype wire

// [src/psepm_dev.sv]
/*
 * Device end: eight per-port mode sequencers with fault power removal.
 * Assumes analogue results arrive as synchronous done pulses.
 */
`timescale 1ns/1ns
`default_nettype none
module psepm_dev
    import psepm_pkg::*;
#(
    parameter int PORTS = PSEPM_PORTS,
    parameter int WAIT_CYC = PSEPM_WAIT_CYC,
    parameter int WAIT_MID_CYC = PSEPM_WAIT_MID_CYC
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    psepm_if.dev link,
    input wire logic auto_strap,
    input wire logic midspan_strap,
    input wire logic power_select_strap0,
    input wire logic power_select_strap1,
    input wire logic type1_pse,
    output logic [PORTS-1:0] det_start,
    input wire logic [PORTS-1:0] det_done,
    input wire logic [PORTS*3-1:0] det_result,
    output logic [PORTS-1:0] class_start,
    output logic [PORTS-1:0] two_event,
    input wire logic [PORTS-1:0] class_done,
    input wire logic [PORTS*3-1:0] class_result,
    input wire logic [PORTS-1:0] ilim_fault,
    input wire logic [PORTS-1:0] disconnect,
    output logic [PORTS-1:0] power_en,
    output logic [PORTS*10-1:0] icut_ma,
    output logic [PORTS*10-1:0] ilim_ma,
    output logic [PORTS*10-1:0] alloc_pwr,
    output logic ext_power_active,
    output logic [9:0] max_power
);
    // Refuse sizes the sequencers and the 27-bit backoff cannot serve
    if (PORTS != PSEPM_PORTS || WAIT_CYC < 1 || WAIT_MID_CYC < 1
        || WAIT_CYC >= 2**27 || WAIT_MID_CYC >= 2**27)
    begin : g_bad_param
        $error("psepm_dev: unsupported parameters");
    end

    typedef struct packed {
        psepm_state_t st;
        logic [2:0] det;
        logic [2:0] cls;
        logic [9:0] cut;
        logic [9:0] lim;
        logic [9:0] pwr;
        logic fault;
        logic [26:0] cnt;
        logic [1:0] last_mode;
    } psepm_port_t;

    typedef struct packed {
        logic init;
        logic auto_s;
        logic mid_s;
        logic [9:0] maxp;
        psepm_port_t [PSEPM_PORTS-1:0] p;
    } psepm_dev_t;

    psepm_dev_t r;
    psepm_dev_t next_r;

    // Class requested power in tenths of a watt
    function automatic logic [9:0] class_power(input logic [2:0] c);
        unique case (c)
            3'h1: class_power = 10'h028;
            3'h2: class_power = 10'h046;
            3'h4: class_power = 10'h0ff;
            3'h5: class_power = PSEPM_PWR_527;
            3'h6: class_power = PSEPM_PWR_700;
            3'h7: class_power = PSEPM_PWR_900;
            default: class_power = PSEPM_PWR_BASE;
        endcase
    endfunction : class_power

    ////////////////////////////////////////////////////////////////////
    // Per-port sequencing
    always_comb
    begin
        logic [1:0] m;
        logic is_auto;
        logic cmd_here;
        logic [2:0] c;
        next_r = r;
        m = 2'h0;
        is_auto = 1'b0;
        cmd_here = 1'b0;
        c = 3'h0;
        // Straps caught once after reset release
        if (!r.init)
        begin
            next_r.init = 1'b1;
            next_r.auto_s = auto_strap;
            next_r.mid_s = midspan_strap;
            unique case ({power_select_strap1, power_select_strap0})
                2'h0: next_r.maxp = PSEPM_PWR_387;
                2'h1: next_r.maxp = PSEPM_PWR_527;
                2'h2: next_r.maxp = PSEPM_PWR_700;
                default: next_r.maxp = PSEPM_PWR_900;
            endcase
        end
        for (int i = 0; i < PSEPM_PORTS; i++)
        begin
            m = link.mode_field[i*2 +: 2];
            // 11b is reserved and treated as shutdown without strap
            is_auto = (m == PSEPM_MODE_AUTO) && r.auto_s;
            cmd_here = link.cmd_valid && (link.cmd_port == 3'(i));
            next_r.p[i].last_mode = m;
            if (r.p[i].cnt != '0)
                next_r.p[i].cnt = r.p[i].cnt - 27'h1;
            unique case (r.p[i].st)
                PSEPM_ST_IDLE:
                begin
                    if (m == PSEPM_MODE_MAN && cmd_here)
                    begin
                        if (link.cmd_code == PSEPM_CMD_DETECT)
                            next_r.p[i].st = PSEPM_ST_DETECT;
                        else if (link.cmd_code == PSEPM_CMD_CLASS)
                            next_r.p[i].st = PSEPM_ST_CLASS;
                    end
                    else if ((m == PSEPM_MODE_SEMI || is_auto)
                             && link.det_en[i])
                        next_r.p[i].st = PSEPM_ST_DETECT;
                end
                PSEPM_ST_DETECT:
                    if (det_done[i])
                    begin
                        next_r.p[i].det = det_result[i*3 +: 3];
                        if (m == PSEPM_MODE_MAN)
                            next_r.p[i].st = PSEPM_ST_IDLE;
                        else if (det_result[i*3 +: 3] == PSEPM_DET_GOOD
                                 && link.class_en[i])
                            next_r.p[i].st = PSEPM_ST_CLASS;
                        else
                        begin
                            // Class skipped: baseline allocation
                            next_r.p[i].cls = PSEPM_CLASS_0;
                            next_r.p[i].pwr = PSEPM_PWR_BASE;
                            next_r.p[i].st = PSEPM_ST_WAIT;
                            next_r.p[i].cnt = r.mid_s ? 27'(WAIT_MID_CYC)
                                : 27'(WAIT_CYC);
                        end
                    end
                PSEPM_ST_CLASS:
                    if (class_done[i])
                    begin
                        c = class_result[i*3 +: 3];
                        if (type1_pse && c == PSEPM_CLASS_4)
                            c = PSEPM_CLASS_0;
                        next_r.p[i].cls = c;
                        next_r.p[i].pwr = class_power(c);
                        if (m == PSEPM_MODE_MAN)
                            next_r.p[i].st = PSEPM_ST_IDLE;
                        else
                        begin
                            next_r.p[i].st = PSEPM_ST_WAIT;
                            next_r.p[i].cnt = r.mid_s ? 27'(WAIT_MID_CYC)
                                : 27'(WAIT_CYC);
                        end
                        if (is_auto)
                        begin
                            // Thresholds follow the class result
                            unique case (c)
                                3'h1: next_r.p[i].cut = PSEPM_CUT_C1;
                                3'h2: next_r.p[i].cut = PSEPM_CUT_C2;
                                3'h4: next_r.p[i].cut = PSEPM_CUT_C4;
                                default: next_r.p[i].cut = PSEPM_CUT_C3;
                            endcase
                            next_r.p[i].lim = (c == PSEPM_CLASS_4)
                                ? PSEPM_LIM_HI : PSEPM_LIM_LO;
                        end
                    end
                PSEPM_ST_WAIT:
                    if (is_auto && r.p[i].det == PSEPM_DET_GOOD
                        && r.p[i].pwr <= r.maxp)
                        next_r.p[i].st = PSEPM_ST_ON;
                    else if (r.p[i].cnt == '0)
                        next_r.p[i].st = PSEPM_ST_IDLE;
                PSEPM_ST_ON:
                    if (ilim_fault[i])
                        next_r.p[i].st = PSEPM_ST_IDLE;
                    else if (disconnect[i] && link.disc_en[i])
                        next_r.p[i].st = PSEPM_ST_IDLE;
                default:
                    next_r.p[i].st = PSEPM_ST_IDLE;
            endcase
            // Mode change clears the fault; a refusal below still wins
            if (m != r.p[i].last_mode)
                next_r.p[i].fault = 1'b0;
            // Host power commands
            if (cmd_here && link.cmd_code == PSEPM_CMD_PWR_OFF)
                next_r.p[i].st = PSEPM_ST_IDLE;
            else if (cmd_here && link.cmd_code == PSEPM_CMD_PWR_ON
                     && r.p[i].st != PSEPM_ST_ON)
            begin
                if (m == PSEPM_MODE_MAN)
                    next_r.p[i].st = PSEPM_ST_ON;
                else if (m == PSEPM_MODE_SEMI)
                begin
                    // Good detect required whether high_power_en is set or not
                    if (r.p[i].det == PSEPM_DET_GOOD)
                        next_r.p[i].st = PSEPM_ST_ON;
                    else
                        next_r.p[i].fault = 1'b1;
                end
            end
            // Shutdown or reserved code aborts everything
            if (m == PSEPM_MODE_SHUT
                || (m == PSEPM_MODE_AUTO && !r.auto_s))
            begin
                next_r.p[i].st = PSEPM_ST_IDLE;
                next_r.p[i].cnt = '0;
            end
        end
    end

    // State register with reset defaults
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            r <= '0;
        else
            r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb
    begin
        for (int i = 0; i < PSEPM_PORTS; i++)
        begin
            power_en[i] = (r.p[i].st == PSEPM_ST_ON);
            det_start[i] = (r.p[i].st == PSEPM_ST_DETECT);
            class_start[i] = (r.p[i].st == PSEPM_ST_CLASS);
            two_event[i] = !type1_pse;
            icut_ma[i*10 +: 10] = r.p[i].cut;
            ilim_ma[i*10 +: 10] = r.p[i].lim;
            alloc_pwr[i*10 +: 10] = r.p[i].pwr;
            link.port_power[i] = (r.p[i].st == PSEPM_ST_ON);
            link.startup_fault[i] = r.p[i].fault;
            link.det_status[i*3 +: 3] = r.p[i].det;
            link.class_status[i*3 +: 3] = r.p[i].cls;
        end
    end

    assign ext_power_active = link.high_power_en && link.ext_power_en;
    assign max_power = r.maxp;
    assign link.auto_sampled = r.auto_s;
endmodule : psepm_dev
`default_nettype wire

// [sim/psepm_sva.sv]
/*
 * Checker on the carrier between host end and device end.
 * Assumes one ref_clk domain and the active-low resetn.
 */
`timescale 1ns/1ns
`default_nettype none
module psepm_sva
    import psepm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_port,
    input wire logic [2:0] cmd_code,
    input wire logic [15:0] mode_field,
    input wire logic high_power_en,
    input wire logic [7:0] port_power,
    input wire logic [7:0] startup_fault,
    input wire logic [23:0] det_status,
    input wire logic auto_sampled
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // Decoded command and the mode of its target port
    logic is_on;
    logic is_off;
    logic [1:0] cmd_mode;
    assign is_on = cmd_valid && cmd_code == PSEPM_CMD_PWR_ON;
    assign is_off = cmd_valid && cmd_code == PSEPM_CMD_PWR_OFF;
    assign cmd_mode = mode_field[{cmd_port, 1'b0} +: 2];

    ////////////////////////////////////////////////////////////////////////
    property p_on_manual;
        is_on && cmd_mode == PSEPM_MODE_MAN |=> port_power[$past(cmd_port)];
    endproperty
    a_on_manual: assert property (p_on_manual)
        else $error("manual power-on not applied");
    property p_off_cmd;
        is_off |=> !port_power[$past(cmd_port)];
    endproperty
    a_off_cmd: assert property (p_off_cmd)
        else $error("power-off command not applied");
    property p_semi_refuse;
        is_on && cmd_mode == PSEPM_MODE_SEMI && high_power_en
            && !port_power[cmd_port]
            && det_status[cmd_port * 5'd3 +: 3] != PSEPM_DET_GOOD
            |=> startup_fault[$past(cmd_port)]
            && !port_power[$past(cmd_port)];
    endproperty
    a_semi_refuse: assert property (p_semi_refuse)
        else $error("semi power-on without good detect not refused");
    property p_reset_dflt;
        $rose(resetn) |-> port_power == 8'h00 && startup_fault == 8'h00;
    endproperty
    a_reset_dflt: assert property (p_reset_dflt)
        else $error("port state not cleared by reset");
    property p_strap_hold;
        $past(resetn, 2) |-> $stable(auto_sampled);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("strap copy changed outside reset");

    // Per-port relations
    for (genvar p = 0; p < 8; p++)
    begin : g_port
        property p_shutdown;
            mode_field[2*p +: 2] == PSEPM_MODE_SHUT |=> !port_power[p];
        endproperty
        a_shutdown: assert property (p_shutdown)
            else $error("power on a port in shutdown");
        property p_reserved;
            mode_field[2*p +: 2] == PSEPM_MODE_AUTO && !auto_sampled
                |=> !port_power[p];
        endproperty
        a_reserved: assert property (p_reserved)
            else $error("power in reserved mode");
        property p_self_power;
            $rose(port_power[p]) |-> $past(is_on && cmd_port == p)
                || mode_field[2*p +: 2] == PSEPM_MODE_AUTO && auto_sampled;
        endproperty
        a_self_power: assert property (p_self_power)
            else $error("power rose without command");
        property p_fault_rise;
            $rose(startup_fault[p]) |-> $past(is_on && cmd_port == p);
        endproperty
        a_fault_rise: assert property (p_fault_rise)
            else $error("startup fault without power-on command");
    end

    // Main scenarios
    c_manual_on: cover property (is_on && cmd_mode == PSEPM_MODE_MAN);
    c_refuse: cover property ($rose(startup_fault[5]));
    c_auto_on: cover property ($rose(port_power[7]));
endmodule : psepm_sva
`default_nettype wire

// [sim/tb_pse_port_mode_controller.sv]
/*
 * Testbench joining host end and device end over the carrier.
 * Assumes the analogue side answers each detect and class at once.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_pse_port_mode_controller
    import psepm_pkg::*;
;
    logic ref_clk, resetn, u_valid, cfg_we, c_det, c_cls, c_disc;
    logic hp, ext, auto_strap, mid, ps0, ps1, type1, ext_act, seen, two_seen;
    logic [2:0] u_port, u_code, c_port;
    logic [1:0] c_mode;
    logic [7:0] user_power, user_fault, det_start, det_done, class_start;
    logic [7:0] two_event, class_done, ilim, disc, power_en;
    logic [23:0] det_res, cls_res;
    logic [79:0] icut, ilim_ma, alloc;
    logic [9:0] max_power;
    logic [9:0] pw [4] = '{PSEPM_PWR_900, PSEPM_PWR_700, PSEPM_PWR_527,
        PSEPM_PWR_387};
    int n_errors, compares, c;

    psepm_if link_if();
    psepm_host psepm_host_inst (.ref_clk(ref_clk), .resetn(resetn),
        .link(link_if), .user_cmd_valid(u_valid), .user_cmd_port(u_port),
        .user_cmd_code(u_code), .cfg_we(cfg_we), .cfg_port(c_port),
        .cfg_mode(c_mode), .cfg_det_en(c_det), .cfg_class_en(c_cls),
        .cfg_disc_en(c_disc), .cfg_high_power_en(hp),
        .cfg_ext_power_en(ext), .user_power(user_power),
        .user_fault(user_fault));
    psepm_dev #(.WAIT_CYC(10), .WAIT_MID_CYC(20)) psepm_dev_inst (
        .ref_clk(ref_clk), .resetn(resetn), .link(link_if),
        .auto_strap(auto_strap), .midspan_strap(mid),
        .power_select_strap0(ps0), .power_select_strap1(ps1),
        .type1_pse(type1), .det_start(det_start), .det_done(det_done),
        .det_result(det_res), .class_start(class_start),
        .two_event(two_event), .class_done(class_done),
        .class_result(cls_res), .ilim_fault(ilim), .disconnect(disc),
        .power_en(power_en), .icut_ma(icut), .ilim_ma(ilim_ma),
        .alloc_pwr(alloc), .ext_power_active(ext_act),
        .max_power(max_power));
    psepm_sva psepm_sva_inst (.ref_clk(ref_clk), .resetn(resetn),
        .cmd_valid(link_if.cmd_valid), .cmd_port(link_if.cmd_port),
        .cmd_code(link_if.cmd_code), .mode_field(link_if.mode_field),
        .high_power_en(link_if.high_power_en),
        .port_power(link_if.port_power),
        .startup_fault(link_if.startup_fault),
        .det_status(link_if.det_status),
        .auto_sampled(link_if.auto_sampled));

    ////////////////////////////////////////////////////////////////////////
    // Clock of 40 ns
    always #20 ref_clk = ~ref_clk;

    // Analogue side: one done pulse per started detect or class
    always @(negedge ref_clk)
    begin
        det_done <= det_start & ~det_done;
        class_done <= class_start & ~class_done;
        if (type1 && two_event !== 8'h00)
            two_seen <= 1'b1;
    end

    task automatic chk(input string name, input logic [31:0] s, x);
        compares++;
        if (s !== x)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, x, s);
        end
    endtask : chk

    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic rst(input logic a, input logic [1:0] s);
        @(negedge ref_clk);
        resetn = 1'b0;
        auto_strap = a;
        {ps1, ps0} = s;
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask : rst

    task automatic cmd(input int p, input logic [2:0] code);
        @(negedge ref_clk);
        {u_valid, u_port, u_code} = {1'b1, 3'(p), code};
        @(negedge ref_clk);
        u_valid = 1'b0;
    endtask : cmd

    task automatic cfg(input int p, input logic [1:0] m, input logic d, cl,
        di);
        @(negedge ref_clk);
        {cfg_we, c_port, c_mode, c_det, c_cls, c_disc} =
            {1'b1, 3'(p), m, d, cl, di};
        @(negedge ref_clk);
        cfg_we = 1'b0;
    endtask : cfg

    // Bounded wait for power (pw_sel) or detect start of a port
    task automatic wt(input int p, input logic pw_sel, v);
        c = 0;
        while ((pw_sel ? power_en[p] : det_start[p]) !== v)
        begin
            c++;
            @(negedge ref_clk);
            if (c > 200)
            begin
                n_errors++;
                $display("unexpected timeout: port %0d expected %b", p, v);
                end_sim();
            end
        end
    endtask : wt

    task automatic watch(input int p, n);
        seen = 1'b0;
        repeat (n) @(negedge ref_clk) seen = seen | det_start[p] | power_en[p];
    endtask : watch

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {ref_clk, resetn, u_valid, cfg_we, type1, mid, ps0, ps1} = '0;
        {u_port, u_code, c_port, c_mode, c_det, c_cls, c_disc} = '0;
        {det_done, class_done, ilim, disc, two_seen} = '0;
        {hp, ext, auto_strap} = 3'b101;
        det_res = {8{PSEPM_DET_GOOD}};
        det_res[17:15] = 3'h1;
        cls_res = {3'h1, 3'h7, 9'h0, PSEPM_CLASS_4, 6'h0};
        // Power limit straps, last one 00
        for (int i = 0; i < 4; i++)
        begin
            rst(1'b1, 2'(3 - i));
            chk("max power", max_power, pw[i]);
        end
        ps1 = 1'b1;
        repeat (5) @(negedge ref_clk);
        chk("max power held", max_power, PSEPM_PWR_387);
        chk("auto copy", link_if.auto_sampled, 1'b1);
        // Manual detect, power and fault removal
        cfg(1, PSEPM_MODE_MAN, 1'b0, 1'b0, 1'b0);
        chk("ext active", ext_act, 1'b0);
        cmd(1, PSEPM_CMD_DETECT);
        repeat (5) @(negedge ref_clk);
        chk("manual status", link_if.det_status[5:3], PSEPM_DET_GOOD);
        watch(1, 20);
        chk("manual idle", seen, 1'b0);
        cmd(1, PSEPM_CMD_PWR_ON);
        wt(1, 1'b1, 1'b1);
        cfg(2, PSEPM_MODE_MAN, 1'b0, 1'b0, 1'b0);
        cfg(3, PSEPM_MODE_MAN, 1'b0, 1'b0, 1'b1);
        cfg(4, PSEPM_MODE_MAN, 1'b0, 1'b0, 1'b0);
        cmd(2, PSEPM_CMD_PWR_ON);
        cmd(3, PSEPM_CMD_PWR_ON);
        cmd(4, PSEPM_CMD_PWR_ON);
        wt(4, 1'b1, 1'b1);
        chk("ports on", power_en[3:2], 2'h3);
        {ilim[2], disc[3], disc[4]} = 3'h7;
        repeat (4) @(negedge ref_clk);
        chk("limit fault off", power_en[2], 1'b0);
        chk("disconnect off", power_en[3], 1'b0);
        chk("disconnect kept", user_power[4], 1'b1);
        chk("other port", power_en[1], 1'b1);
        cmd(1, PSEPM_CMD_PWR_OFF);
        wt(1, 1'b1, 1'b0);
        // Semi-auto repeat, refusal, then good power-on
        cfg(5, PSEPM_MODE_SEMI, 1'b1, 1'b0, 1'b0);
        wt(5, 1'b0, 1'b1);
        wt(5, 1'b0, 1'b0);
        wt(5, 1'b0, 1'b1);
        chk("redetect gap", c >= 10, 1'b1);
        chk("semi no power", power_en[5], 1'b0);
        cmd(5, PSEPM_CMD_PWR_ON);
        repeat (3) @(negedge ref_clk);
        chk("startup fault", user_fault[5], 1'b1);
        det_res[17:15] = PSEPM_DET_GOOD;
        wt(5, 1'b0, 1'b0);
        wt(5, 1'b0, 1'b1);
        wt(5, 1'b0, 1'b0);
        cmd(5, PSEPM_CMD_PWR_ON);
        wt(5, 1'b1, 1'b1);
        cfg(6, PSEPM_MODE_SEMI, 1'b0, 1'b0, 1'b0);
        watch(6, 30);
        chk("no detect enable", seen, 1'b0);
        // Strap-auto ports
        cfg(6, PSEPM_MODE_AUTO, 1'b1, 1'b1, 1'b0);
        wt(6, 1'b0, 1'b1);
        wt(6, 1'b0, 1'b0);
        wt(6, 1'b0, 1'b1);
        chk("over limit", power_en[6], 1'b0);
        cfg(7, PSEPM_MODE_AUTO, 1'b1, 1'b1, 1'b0);
        wt(7, 1'b1, 1'b1);
        chk("cut class 1", icut[79:70], PSEPM_CUT_C1);
        chk("lim class 1", ilim_ma[79:70], PSEPM_LIM_LO);
        cfg(7, PSEPM_MODE_SHUT, 1'b0, 1'b0, 1'b0);
        repeat (2) @(negedge ref_clk);
        chk("shutdown off", power_en[7], 1'b0);
        watch(7, 30);
        chk("shutdown idle", seen, 1'b0);
        ilim[2] = 1'b0;
        type1 = 1'b1;
        cfg(2, PSEPM_MODE_AUTO, 1'b1, 1'b1, 1'b0);
        wt(2, 1'b1, 1'b1);
        chk("class 4 as 0", icut[29:20], PSEPM_CUT_C3);
        chk("class status", link_if.class_status[8:6], PSEPM_CLASS_0);
        chk("two event", two_seen, 1'b0);
        type1 = 1'b0;
        cfg(0, PSEPM_MODE_AUTO, 1'b1, 1'b0, 1'b0);
        wt(0, 1'b1, 1'b1);
        chk("skipped class", alloc[9:0], PSEPM_PWR_BASE);
        ext = 1'b1;
        cfg(0, PSEPM_MODE_AUTO, 1'b1, 1'b0, 1'b0);
        chk("ext active", ext_act, 1'b1);
        // Reset without the auto strap
        rst(1'b0, 2'h0);
        chk("reset power", power_en, 8'h00);
        chk("auto copy", link_if.auto_sampled, 1'b0);
        cfg(1, PSEPM_MODE_AUTO, 1'b1, 1'b1, 1'b0);
        cmd(1, PSEPM_CMD_PWR_ON);
        watch(1, 30);
        chk("reserved mode", seen, 1'b0);
        end_sim();
    end
endmodule : tb_pse_port_mode_controller
`default_nettype wire
